// ### scz_load_timing.v
/*
  Shift-load strobe and shift-clock gate generator for base and window
  screens, with horizontal smooth scroll and horizontal zoom.
  Assumes pclk is the dot clock, the display processor inputs arrive
  asynchronously on pins, and software programs the block over APB.
*/
// The address map and the APB register port were decided locally.
// Overview of operation
// - WSS=1 dual1: base fixed, window scrolled
// - Scroll code: attribute low, address bits high
// - Shift length masks scroll code bits
// - Latch two address bits every display cycle
// - Divide ratio sets cycle and shift length
// - Priority mode blanks after 32 shifted bits
// - Shift gate rate is dot rate over zoom plus one
// - WSS=0 single/dual0: base scrolled, no window
// - WSS=0 dual1: window on last dot
// - Each scroll dot moves strobe earlier
`include "scz_regs.vh"

module scz_load_timing (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`SCZ_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [3:0] scroll_attr,
  input wire [3:0] zoom_code,
  input wire address_bit_zero,
  input wire address_bit_one,
  input wire display_cycle_flag,
  output reg base_load_strobe,
  output reg window_load_strobe,
  output reg shift_clock_gate,
  output reg display_enable
);

  // --------------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------------
  // Control register selected by an APB address.
  function is_ctrl;
    input [`SCZ_ADDR_W-1:0] a;
    begin
      is_ctrl = (a == `SCZ_CTRL_OFFSET);
    end
  endfunction

  function addr_ok;
    input [`SCZ_ADDR_W-1:0] a;
    begin
      addr_ok = (a == `SCZ_CTRL_OFFSET) || (a == `SCZ_STATUS_OFFSET);
    end
  endfunction

  // Dots in one display cycle for a clock divide code.
  function [5:0] cycle_len;
    input [1:0] cds;
    begin
      case (cds)
        `SCZ_CDS_DIV16: cycle_len = 6'h20;
        `SCZ_CDS_DIV8: cycle_len = 6'h10;
        default: cycle_len = 6'h08;
      endcase
    end
  endfunction

  // Mask of scroll code bits that count for a shift length.
  function [5:0] scroll_mask;
    input [6:0] shift_len;
    begin
      if (shift_len[6])
        scroll_mask = 6'h3f;
      else if (shift_len[5])
        scroll_mask = 6'h1f;
      else if (shift_len[4])
        scroll_mask = 6'h0f;
      else
        scroll_mask = 6'h07;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Control register
  // --------------------------------------------------------------------------
  reg [`SCZ_CTRL_W-1:0] ctrl;
  wire ctrl_enable = ctrl[`SCZ_CTRL_ENABLE_BIT];
  wire ctrl_soft_reset = ctrl[`SCZ_CTRL_SOFT_RESET_BIT];
  wire ctrl_wss = ctrl[`SCZ_CTRL_WSS_BIT];
  wire ctrl_prio = ctrl[`SCZ_CTRL_PRIO_BIT];
  wire [1:0] ctrl_mode = ctrl[`SCZ_CTRL_MODE_MSB:`SCZ_CTRL_MODE_LSB];
  wire [1:0] clock_divide_select = ctrl[`SCZ_CTRL_CDS_MSB:`SCZ_CTRL_CDS_LSB];

  // --------------------------------------------------------------------------
  // Pin synchronisers and display cycle start detection
  // --------------------------------------------------------------------------
  wire [`SCZ_SYNC_W-1:0] pins_sync;

  scz_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .async_in({display_cycle_flag, address_bit_one, address_bit_zero, zoom_code, scroll_attr}),
    .sync_out(pins_sync)
  );

  wire [3:0] attr_s = pins_sync[3:0];
  wire [3:0] zoom_s = pins_sync[7:4];
  wire addr0_s = pins_sync[8];
  wire addr1_s = pins_sync[9];
  wire dcyc_s = pins_sync[10];
  // The flag passes the same two flops as the pins it qualifies, so the pins
  // latched at a cycle start are at least as old as the flag edge.
  reg dcyc_prev;
  wire cycle_start = dcyc_s & ~dcyc_prev;

  // --------------------------------------------------------------------------
  // Cycle geometry
  // --------------------------------------------------------------------------
  wire [5:0] len = cycle_len(clock_divide_select);
  wire [4:0] last_dot = len[4:0] - 5'h01;
  wire dual = (ctrl_mode != `SCZ_MODE_SINGLE);
  wire [6:0] shift_len = dual ? {len, 1'b0} : {1'b0, len};

  // --------------------------------------------------------------------------
  // Scroll code capture
  // --------------------------------------------------------------------------
  reg [3:0] attr_lat;
  reg address_lat_zero;
  reg address_lat_one;
  wire [5:0] scroll_dot_code = {address_lat_one, address_lat_zero, attr_lat} & scroll_mask(shift_len);
  // The cycle length is a power of two, so masking with the last dot takes
  // the scroll amount modulo the cycle.
  wire [4:0] scroll_in_cycle = scroll_dot_code[4:0] & last_dot;
  wire [4:0] scroll_target = last_dot - scroll_in_cycle;

  // --------------------------------------------------------------------------
  // Dot counter and run state
  // --------------------------------------------------------------------------
  reg [4:0] dot_cnt;
  reg in_cycle;
  reg armed;
  reg [3:0] zoom_cnt;
  reg [5:0] bits_out;

  wire run = armed & ctrl_enable & ~ctrl_soft_reset;
  wire scroll_hit = in_cycle && (dot_cnt == scroll_target);
  wire fixed_hit = in_cycle && (dot_cnt == last_dot);
  wire blank = ctrl_prio && (bits_out >= `SCZ_PRIO_SHIFT_BITS);
  wire gate_now = run && (zoom_cnt == 4'h0);

  reg next_base;
  reg next_window;

  // --------------------------------------------------------------------------
  // Strobe selection by access mode and window scroll select
  // --------------------------------------------------------------------------
  always @* begin
    next_base = 1'b0;
    next_window = 1'b0;
    case (ctrl_mode)
      `SCZ_MODE_DUAL1: begin
        if (ctrl_wss) begin
          next_base = fixed_hit;
          next_window = scroll_hit;
        end else begin
          next_base = scroll_hit;
          next_window = fixed_hit;
        end
      end
      default: begin
        next_base = scroll_hit;
        next_window = 1'b0;
      end
    endcase
    if (!run) begin
      next_base = 1'b0;
      next_window = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Timing state
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcyc_prev <= 1'b0;
      attr_lat <= 4'h0;
      address_lat_zero <= 1'b0;
      address_lat_one <= 1'b0;
      dot_cnt <= 5'h00;
      in_cycle <= 1'b0;
      armed <= 1'b0;
      zoom_cnt <= 4'h0;
      bits_out <= 6'h00;
    end else if (clk_en) begin
      dcyc_prev <= dcyc_s;
      if (ctrl_soft_reset || !ctrl_enable) begin
        armed <= 1'b0;
        in_cycle <= 1'b0;
        dot_cnt <= 5'h00;
        zoom_cnt <= 4'h0;
        bits_out <= 6'h00;
      end else if (cycle_start) begin
        armed <= 1'b1;
        attr_lat <= attr_s;
        address_lat_zero <= addr0_s;
        address_lat_one <= addr1_s;
        dot_cnt <= 5'h00;
        in_cycle <= 1'b1;
        zoom_cnt <= 4'h0;
        bits_out <= 6'h00;
      end else begin
        if (in_cycle) begin
          // A shorter divide chosen mid-cycle ends the cycle instead of wrapping.
          if (dot_cnt >= last_dot)
            in_cycle <= 1'b0;
          else
            dot_cnt <= dot_cnt + 5'h01;
        end
        if (run) begin
          if (zoom_cnt >= zoom_s)
            zoom_cnt <= 4'h0;
          else
            zoom_cnt <= zoom_cnt + 4'h1;
        end
        // The count saturates at the limit, so turning priority mode on
        // mid-line never blanks on a wrapped count.
        if (gate_now && (bits_out < `SCZ_PRIO_SHIFT_BITS))
          bits_out <= bits_out + 6'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_load_strobe <= 1'b0;
      window_load_strobe <= 1'b0;
      shift_clock_gate <= 1'b0;
      display_enable <= 1'b0;
    end else if (clk_en) begin
      base_load_strobe <= next_base;
      window_load_strobe <= next_window;
      shift_clock_gate <= gate_now;
      display_enable <= run && !blank;
    end
  end

  // --------------------------------------------------------------------------
  // Status word
  // --------------------------------------------------------------------------
  reg [31:0] status_word;

  always @* begin
    status_word = 32'h0000_0000;
    status_word[`SCZ_STAT_CODE_MSB:`SCZ_STAT_CODE_LSB] = scroll_dot_code;
    status_word[`SCZ_STAT_DOT_MSB:`SCZ_STAT_DOT_LSB] = dot_cnt;
    status_word[`SCZ_STAT_IN_CYCLE_BIT] = in_cycle;
    status_word[`SCZ_STAT_ARMED_BIT] = armed;
    status_word[`SCZ_STAT_BLANK_BIT] = blank;
  end

  // --------------------------------------------------------------------------
  // APB slave with one wait state
  // --------------------------------------------------------------------------
  // Every access takes exactly one wait state: pready rises at the first
  // access edge and falls at the edge that completes the transfer.
  wire access_first = psel && penable && !pready;
  wire access_done = psel && penable && pready;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `SCZ_CTRL_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      if (access_first) begin
        pready <= 1'b1;
        pslverr <= !addr_ok(paddr);
        if (!pwrite && is_ctrl(paddr))
          prdata <= {{(32-`SCZ_CTRL_W){1'b0}}, ctrl};
        else if (!pwrite && paddr == `SCZ_STATUS_OFFSET)
          prdata <= status_word;
        else
          prdata <= 32'h0000_0000;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        if (access_done && pwrite && is_ctrl(paddr))
          ctrl <= pwdata[`SCZ_CTRL_W-1:0];
      end
    end
  end

endmodule

// ### scz_regs.vh
/*
  Offsets, field positions, codes and reset values of the scroll and zoom
  load-timing block.
  Assumes inclusion by bare name from the design files of this folder.
*/
`ifndef SCZ_REGS_VH
`define SCZ_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets on the APB slave
// ----------------------------------------------------------------------------
`define SCZ_ADDR_W 12
`define SCZ_CTRL_OFFSET 12'h000
`define SCZ_STATUS_OFFSET 12'h004

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define SCZ_CTRL_W 8
`define SCZ_CTRL_RESET 8'h42
`define SCZ_CTRL_ENABLE_BIT 0
`define SCZ_CTRL_SOFT_RESET_BIT 1
`define SCZ_CTRL_WSS_BIT 2
`define SCZ_CTRL_PRIO_BIT 3
`define SCZ_CTRL_MODE_LSB 4
`define SCZ_CTRL_MODE_MSB 5
`define SCZ_CTRL_CDS_LSB 6
`define SCZ_CTRL_CDS_MSB 7

// ----------------------------------------------------------------------------
// Access modes and clock divide codes
// ----------------------------------------------------------------------------
`define SCZ_MODE_SINGLE 2'h0
`define SCZ_MODE_DUAL0 2'h1
`define SCZ_MODE_DUAL1 2'h2
`define SCZ_CDS_DIV4 2'h1
`define SCZ_CDS_DIV8 2'h2
`define SCZ_CDS_DIV16 2'h3

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define SCZ_STAT_CODE_LSB 0
`define SCZ_STAT_CODE_MSB 5
`define SCZ_STAT_DOT_LSB 6
`define SCZ_STAT_DOT_MSB 10
`define SCZ_STAT_IN_CYCLE_BIT 11
`define SCZ_STAT_ARMED_BIT 12
`define SCZ_STAT_BLANK_BIT 13

// ----------------------------------------------------------------------------
// Counts
// ----------------------------------------------------------------------------
`define SCZ_PRIO_SHIFT_BITS 6'h20
`define SCZ_SYNC_W 11

`endif

// ### scz_sync.v
/*
  Two-stage synchroniser for the pin inputs of the load-timing block.
  Assumes every bit is an independent level; multi-bit codes must be held
  stable by the sender while they are used.
*/
`include "scz_regs.vh"

module scz_sync (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire [`SCZ_SYNC_W-1:0] async_in,
  output wire [`SCZ_SYNC_W-1:0] sync_out
);

  // --------------------------------------------------------------------------
  // One two-flop chain per bit
  // --------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < `SCZ_SYNC_W; i = i + 1) begin : g_bit
      reg stage_a;
      reg stage_b;
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage_a <= 1'b0;
          stage_b <= 1'b0;
        end else if (clk_en) begin
          stage_a <= async_in[i];
          stage_b <= stage_a;
        end
      end
      assign sync_out[i] = stage_b;
    end
  endgenerate

endmodule

// ### scz_dp_model.sv
/*
  Display processor pin model: on a line request it sets the scroll,
  address and zoom pins, then raises the display cycle flag four dots later.
  Assumes the same dot clock and reset as the load-timing block.
*/
module scz_dp_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [3:0] attr_in,
  input wire logic a0_in,
  input wire logic a1_in,
  input wire logic [3:0] zoom_in,
  output logic display_cycle_flag,
  output logic [3:0] scroll_attr,
  output logic [3:0] zoom_code,
  output logic address_bit_zero,
  output logic address_bit_one
);
  logic [2:0] step;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step <= 3'h0;
      display_cycle_flag <= 1'b0;
      scroll_attr <= 4'h0;
      zoom_code <= 4'h0;
      address_bit_zero <= 1'b0;
      address_bit_one <= 1'b0;
    end else if (go) begin
      step <= 3'h1;
      scroll_attr <= attr_in;
      zoom_code <= zoom_in;
      address_bit_zero <= a0_in;
      address_bit_one <= a1_in;
    end else if (step != 3'h0) begin
      step <= step + 3'h1;
      display_cycle_flag <= (step == 3'h4) || (step == 3'h5);
    end
  end
endmodule

// ### scz_chk.sv
/*
  Port assertions of the load-timing block, with a shadow of the control word.
  Assumes clk_en stays high.
*/
`include "scz_regs.vh"
module scz_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`SCZ_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire base_load_strobe,
  input wire window_load_strobe,
  input wire shift_clock_gate,
  input wire display_enable
);
  logic [7:0] sh;
  wire idle = sh[`SCZ_CTRL_SOFT_RESET_BIT] | ~sh[`SCZ_CTRL_ENABLE_BIT];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh <= `SCZ_CTRL_RESET;
    end else if (psel && penable && pready && pwrite && paddr == `SCZ_CTRL_OFFSET) begin
      sh <= pwdata[7:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_apb_wait; psel && penable && !pready |=> pready; endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready late");
  property p_apb_once; pready |=> !pready; endproperty
  a_apb_once: assert property (p_apb_once) else $error("pready held");
  property p_apb_err;
    pready |-> pslverr == (paddr != `SCZ_CTRL_OFFSET && paddr != `SCZ_STATUS_OFFSET);
  endproperty
  a_apb_err: assert property (p_apb_err) else $error("pslverr wrong");
  property p_apb_rdz; pready && pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_apb_rdz: assert property (p_apb_rdz) else $error("unmapped read not zero");
  property p_idle;
    $past(idle) |-> !(base_load_strobe || window_load_strobe || shift_clock_gate);
  endproperty
  a_idle: assert property (p_idle) else $error("output active while idle");
  property p_de_idle; $past(idle) |-> !display_enable; endproperty
  a_de_idle: assert property (p_de_idle) else $error("enable while idle");
  property p_no_win; $past(sh[5:4]) != `SCZ_MODE_DUAL1 |-> !window_load_strobe; endproperty
  a_no_win: assert property (p_no_win) else $error("window strobe outside dual1");
  property p_base_pulse; base_load_strobe |=> !base_load_strobe; endproperty
  a_base_pulse: assert property (p_base_pulse) else $error("base strobe too long");
  property p_win_pulse; $rose(window_load_strobe) |=> $fell(window_load_strobe); endproperty
  a_win_pulse: assert property (p_win_pulse) else $error("window strobe too long");
endmodule
bind scz_load_timing scz_chk chk_u (.*);

// ### tb.sv
/*
  Self-checking bench of the load-timing block over APB and the pin model.
  Assumes strobes appear L+3-s edges after the flag edge.
*/
`include "scz_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic go = 0, a0_in = 0, a1_in = 0, e, de10, de60;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [3:0] attr_in = 0, zoom_in = 0;
  wire [31:0] prdata;
  wire [3:0] scroll_attr, zoom_code;
  wire pready, pslverr, display_cycle_flag, address_bit_zero, address_bit_one;
  wire base_load_strobe, window_load_strobe, shift_clock_gate, display_enable;
  int err_count = 0, checked = 0, cyc = 0, tb_t, tw_t, g1, g2;
  int shifts = 0, s10, s60;
  logic [7:0] cc [6] = '{8'h41, 8'h91, 8'he1, 8'he5, 8'hc1, 8'h35};
  logic [5:0] code [6] = '{6'h03, 6'h1f, 6'h35, 6'h12, 6'h10, 6'h0d};
  int be [6] = '{8, 4, 14, 35, 19, 6};
  int we [6] = '{0, 0, 35, 17, 0, 0};
  always #4 pclk = ~pclk;
  // Video shift register model: it advances on the falling dot clock edge.
  always @(negedge pclk)
    if (shift_clock_gate === 1'b1) shifts <= shifts + 1;
  scz_load_timing dut_u (.*);
  scz_dp_model dp_u (.*);
  task summarize;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      summarize();
    end
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task line(input logic [5:0] c, input logic [3:0] z);
    attr_in <= c[3:0];
    a0_in <= c[4];
    a1_in <= c[5];
    zoom_in <= z;
    go <= 1;
    @(posedge pclk) go <= 0;
    {tb_t, tw_t, g1, g2} = 128'h0;
    do begin @(posedge pclk); #1; end while (display_cycle_flag !== 1'b1);
    for (int n = 1; n < 70; n++) begin
      @(posedge pclk);
      #1;
      if (base_load_strobe === 1'b1 && tb_t == 0) tb_t = n;
      if (window_load_strobe === 1'b1 && tw_t == 0) tw_t = n;
      if (shift_clock_gate === 1'b1 && n > 5 && g1 == 0) g1 = n;
      else if (shift_clock_gate === 1'b1 && n > 5 && g2 == 0) g2 = n;
      if (n == 10) de10 = display_enable;
      if (n == 10) s10 = shifts;
      if (n == 60) de60 = display_enable;
      if (n == 60) s60 = shifts;
    end
    @(posedge pclk);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, `SCZ_CTRL_OFFSET, 0);
    chk("ctrl_reset", rd, 32'h42);
    apb(1, 12'h008, 32'hff);
    chk("unmapped_err", e, 1);
    apb(0, 12'h008, 0);
    chk("unmapped_rd", rd, 0);
    apb(1, `SCZ_CTRL_OFFSET, 32'hffff_ff43);
    apb(0, `SCZ_CTRL_OFFSET, 0);
    chk("ctrl_rw", rd, 32'h43);
    $display("register test done");
    line(6'h03, 4'h0);
    chk("srst_base", tb_t, 0);
    chk("srst_gate", g1, 0);
    chk("srst_de", de10, 0);
    $display("soft reset test done");
    for (int i = 0; i < 6; i++) begin
      apb(1, `SCZ_CTRL_OFFSET, {24'h0, cc[i]});
      line(code[i], 4'h0);
      chk("base", tb_t, be[i]);
      chk("window", tw_t, we[i]);
      chk("gate_unit", g2 - g1, 1);
      chk("shift_adv", s60 - s10, 50);
      apb(0, `SCZ_STATUS_OFFSET, 0);
      chk("scroll_code", rd[5:0], code[i]);
    end
    $display("scroll test done");
    apb(1, `SCZ_CTRL_OFFSET, 32'h41);
    for (int z = 2; z < 16; z += 13) begin
      line(6'h00, z[3:0]);
      chk("zoom_gap", g2 - g1, z + 1);
      chk("no_blank", de60, 1);
    end
    $display("zoom test done");
    apb(1, `SCZ_CTRL_OFFSET, 32'h49);
    line(6'h00, 4'h0);
    chk("prio_on", de10, 1);
    chk("prio_blank", de60, 0);
    line(6'h00, 4'h0);
    chk("prio_again", de10, 1);
    $display("priority test done");
    summarize();
  end
endmodule
